// ---- regulator_config_consts.vh ----
// constants for the regulator configuration word block
`ifndef REGULATOR_CONFIG_CONSTS_VH
`define REGULATOR_CONFIG_CONSTS_VH

// ****************************************************************
// register indices and byte addresses (byte address = 4 * index)
// ****************************************************************
`define IDX_CONFIG_WORD     6'd10
`define IDX_STORED_REF      6'd15
`define IDX_VARIATION_LIMIT 6'd16
`define IDX_VOUT_REF_PARAM  6'd19
`define IDX_VOLATILE_REF    6'd49
`define IDX_SOURCE_STATUS   6'd50
`define IDX_SAMPLE_WINDOW   6'd51
`define ADDR_CONFIG_WORD     12'h028
`define ADDR_STORED_REF      12'h03c
`define ADDR_VARIATION_LIMIT 12'h040
`define ADDR_VOUT_REF_PARAM  12'h04c
`define ADDR_VOLATILE_REF    12'h0c4
`define ADDR_SOURCE_STATUS   12'h0c8
`define ADDR_SAMPLE_WINDOW   12'h0cc

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CONFIG_WORD     16'h1f3d
`define RST_STORED_REF      16'h4000
`define RST_VARIATION_LIMIT 16'h1200
`define RST_VOUT_REF_PARAM  16'h0000

// ****************************************************************
// configuration word bit positions
// ****************************************************************
`define BIT_RMS_REG       0
`define BIT_PERIODIC_REF  1
`define BIT_OFFSET_COMP   2
`define BIT_SHORT_WINDOW  3
`define BIT_JUMPER_READ   4
`define BIT_INVERT_ALARM  5
`define BIT_UNUSED6       6
`define BIT_RAM_CTRL      7
`define BIT_EN_VOLTAGE_TRIMMER_TRIM  8
`define BIT_EN_STAB_TRIM  9
`define BIT_EN_HZ_TRIM    10
`define BIT_EN_AMP_TRIM   11
`define BIT_EN_EXT_INPUT  12
`define BIT_EN_EXT_DAC    13
`define BIT_SEL_60HZ      14
`define BIT_RESERVED15    15

// ****************************************************************
// reference source codes and sample windows
// ****************************************************************
`define SRC_ANALOG_FREE 2'd0
`define SRC_ANALOG_SAT  2'd1
`define SRC_STORED      2'd2
`define SRC_VOLATILE    2'd3
`define WINDOW_SHORT    8'd32
`define WINDOW_LONG     8'd64

`endif

// ---- regulator_config_word.v ----
// configuration word register bank with reference source selection over apb
`timescale 1ns/1ps
`include "regulator_config_consts.vh"

// What this block does
// - each configuration bit except six and fifteen enables its function when one; bit seven depends on bit twelve, bit fourteen on bit four.
// - bit two set enables offset compensation; reset value sets it.
// - bit three set selects a thirty-two sample measurement window.
// - with jumper reading off, bit fourteen picks sixty or fifty hertz.
// - bit twelve enables the analogue input, otherwise digital reference.
// - bit seven meaning depends on the analogue input enable bit.
// - analogue mode with bit seven set saturates at input limit.
// - saturated mode with lost input drives output to stored reference plus variation limit.
// - stored-parameter mode loads and tracks the volatile reference.
// - writes to the volatile reference are ignored in stored mode.
// - digital mode with bit seven set uses the volatile reference.
// - a cleared voltage trimmer enable (bit eight) substitutes the stored parameter value.
module regulator_config_word #(
  parameter DATA_W  = 16,
  parameter ANA_MAX = 16'h7fff
) (
  input  wire              core_clk,
  input  wire              rstn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg               pready,
  output reg  [31:0]       prdata,
  output reg               pslverr,
  input  wire              jumper60Hz,
  input  wire [DATA_W-1:0] analogInput,
  input  wire              analogLost,
  input  wire [DATA_W-1:0] voltageTrimmer,
  input  wire              alarmRaw,
  output reg  [DATA_W-1:0] activeReference,
  output reg  [1:0]        refSource,
  output reg               saturated,
  output reg               offsetCompEn,
  output reg  [7:0]        sampleWindow,
  output reg               select60Hz,
  output reg  [DATA_W-1:0] voltageSetting,
  output reg               alarm_output_contact,
  output reg               rmsRegulation,
  output reg               periodicRefEn,
  output reg               stabTrimEn,
  output reg               hzTrimEn,
  output reg               ampTrimEn,
  output reg               extDacEn
);

  // ****************************************************************
  // parameter storage
  // ****************************************************************
  reg  [15:0]       configWord;
  reg  [15:0]       storedRef;
  reg  [15:0]       variationLimit;
  reg  [15:0]       voutRefParam;
  reg  [DATA_W-1:0] volatileRef;
  reg  [DATA_W-1:0] next_reference;
  reg  [1:0]        next_source;
  reg  [31:0]       next_rdata;
  reg               next_err;
  reg               addrHit;

  wire access    = psel & penable & ~pready;
  wire wrStrobe  = access & pwrite & ~next_err;
  wire extEn     = configWord[`BIT_EN_EXT_INPUT];
  wire ramCtrl   = configWord[`BIT_RAM_CTRL];
  wire storedSel = ~extEn & ~ramCtrl;
  wire [16:0] limitSum = {1'b0, storedRef} + {1'b0, variationLimit};

  // ****************************************************************
  // analogue limit and lost-link target
  // ****************************************************************
  // clamp point cut to the data width on purpose
  localparam [DATA_W-1:0] ANA_CAP = ANA_MAX[DATA_W-1:0];
  // analogue control at or beyond its input limit
  wire              atLimit    = (analogInput >= ANA_CAP);
  // stored reference plus the allowed rise, clipped at full scale so it cannot wrap
  wire [DATA_W-1:0] lostTarget = limitSum[16] ? {DATA_W{1'b1}} : limitSum[DATA_W-1:0];

  // ****************************************************************
  // apb address decode and read mux
  // ****************************************************************
  // one wait state: pready rises at the end of the first access cycle, answer at the edge after that
  always @* begin
    next_rdata = 32'h0000_0000;
    addrHit    = 1'b1;
    case (paddr)
      `ADDR_CONFIG_WORD:     next_rdata = {16'h0000, configWord};
      `ADDR_STORED_REF:      next_rdata = {16'h0000, storedRef};
      `ADDR_VARIATION_LIMIT: next_rdata = {16'h0000, variationLimit};
      `ADDR_VOUT_REF_PARAM:  next_rdata = {16'h0000, voutRefParam};
      `ADDR_VOLATILE_REF:    next_rdata = {{(32-DATA_W){1'b0}}, volatileRef};
      `ADDR_SOURCE_STATUS:   next_rdata = {29'h0000_0000, saturated, refSource};
      `ADDR_SAMPLE_WINDOW:   next_rdata = {24'h00_0000, sampleWindow};
      default:               addrHit = 1'b0;
    endcase
    // unmapped or misaligned addresses answer with an error
    next_err = ~addrHit | (paddr[1:0] != 2'b00);
  end

  // apb handshake: ready and error pulse for one cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access & next_err;
    end
  end

  // read data holds until the next read, refused reads return zero
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (access & ~pwrite) begin
      prdata <= next_err ? 32'h0000_0000 : next_rdata;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  // one select per writable location, refused addresses never match
  wire wrConfig   = wrStrobe & (paddr == `ADDR_CONFIG_WORD);
  wire wrStored   = wrStrobe & (paddr == `ADDR_STORED_REF);
  wire wrLimit    = wrStrobe & (paddr == `ADDR_VARIATION_LIMIT);
  wire wrVoutRef  = wrStrobe & (paddr == `ADDR_VOUT_REF_PARAM);
  wire wrVolatile = wrStrobe & (paddr == `ADDR_VOLATILE_REF);

  // configuration word, whole word stored as written, bits six and fifteen included
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      configWord <= `RST_CONFIG_WORD;
    end else if (wrConfig) begin
      configWord <= pwdata[15:0];
    end
  end

  // stored reference, the nonvolatile digital setpoint
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      storedRef <= `RST_STORED_REF;
    end else if (wrStored) begin
      storedRef <= pwdata[15:0];
    end
  end

  // variation limit, the largest rise above the stored reference
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      variationLimit <= `RST_VARIATION_LIMIT;
    end else if (wrLimit) begin
      variationLimit <= pwdata[15:0];
    end
  end

  // voltage setpoint used while the voltage trimmer is disabled
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      voutRefParam <= `RST_VOUT_REF_PARAM;
    end else if (wrVoutRef) begin
      voutRefParam <= pwdata[15:0];
    end
  end

  // volatile reference: tracks the stored value only while bits twelve and seven are both clear
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      volatileRef <= `RST_STORED_REF;
    end else if (storedSel) begin
      volatileRef <= storedRef[DATA_W-1:0];
    end else if (wrVolatile) begin
      volatileRef <= pwdata[DATA_W-1:0];
    end
  end

  // ****************************************************************
  // reference source selection
  // ****************************************************************
  // the four-way choice of bits twelve and seven
  always @* begin
    next_source    = `SRC_STORED;
    next_reference = storedRef[DATA_W-1:0];
    case ({extEn, ramCtrl})
      2'b10: begin
        next_source    = `SRC_ANALOG_FREE;
        next_reference = analogInput;
      end
      2'b11: begin
        next_source    = `SRC_ANALOG_SAT;
        next_reference = atLimit ? ANA_CAP : analogInput;
        // a lost link outranks the clamp, so a dead input never reads as in range
        // lost link goes to stored reference plus variation limit
        if (analogLost) begin
          next_reference = lostTarget;
        end
      end
      2'b01: begin
        next_source    = `SRC_VOLATILE;
        next_reference = volatileRef;
      end
      default: begin
        next_source    = `SRC_STORED;
        next_reference = storedRef[DATA_W-1:0];
      end
    endcase
  end

  // ****************************************************************
  // registered reference outputs
  // ****************************************************************
  // selected reference and its source code
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      activeReference <= {DATA_W{1'b0}};
      refSource       <= `SRC_ANALOG_FREE;
    end else begin
      activeReference <= next_reference;
      refSource       <= next_source;
    end
  end

  // saturation flag: clamp or lost link, only in the saturating mode
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      saturated <= 1'b0;
    end else begin
      saturated <= (next_source == `SRC_ANALOG_SAT) & (analogLost | atLimit);
    end
  end

  // ****************************************************************
  // function enable outputs, all registered
  // ****************************************************************
  // offset compensation of the acquisition channels
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      offsetCompEn <= 1'b0;
    end else begin
      offsetCompEn <= configWord[`BIT_OFFSET_COMP];
    end
  end

  // measurement window length in samples
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sampleWindow <= `WINDOW_LONG;
    end else begin
      sampleWindow <= configWord[`BIT_SHORT_WINDOW] ? `WINDOW_SHORT : `WINDOW_LONG;
    end
  end

  // nominal frequency, jumper level or configuration bit
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      select60Hz <= 1'b0;
    end else begin
      select60Hz <= configWord[`BIT_JUMPER_READ] ? jumper60Hz : configWord[`BIT_SEL_60HZ];
    end
  end

  // voltage setting, trimmer reading or stored parameter
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      voltageSetting <= {DATA_W{1'b0}};
    end else begin
      voltageSetting <= configWord[`BIT_EN_VOLTAGE_TRIMMER_TRIM] ? voltageTrimmer : voutRefParam[DATA_W-1:0];
    end
  end

  // alarm contact, polarity follows the inversion bit
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      alarm_output_contact <= 1'b0;
    end else begin
      alarm_output_contact <= alarmRaw ^ configWord[`BIT_INVERT_ALARM];
    end
  end

  // rms regulation mode
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rmsRegulation <= 1'b0;
    end else begin
      rmsRegulation <= configWord[`BIT_RMS_REG];
    end
  end

  // periodic reference variation
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      periodicRefEn <= 1'b0;
    end else begin
      periodicRefEn <= configWord[`BIT_PERIODIC_REF];
    end
  end

  // trimmer enables, the regulation loop swaps in parameters when low
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stabTrimEn <= 1'b0;
      hzTrimEn   <= 1'b0;
      ampTrimEn  <= 1'b0;
    end else begin
      stabTrimEn <= configWord[`BIT_EN_STAB_TRIM];
      hzTrimEn   <= configWord[`BIT_EN_HZ_TRIM];
      ampTrimEn  <= configWord[`BIT_EN_AMP_TRIM];
    end
  end

  // external converter enable
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      extDacEn <= 1'b0;
    end else begin
      extDacEn <= configWord[`BIT_EN_EXT_DAC];
    end
  end

endmodule // regulator_config_word

// ---- regulator_config_word_properties.sv ----
// checker properties for the configuration word block
`timescale 1ns/1ps
`include "regulator_config_consts.vh"
module regulator_config_word_properties #(
  parameter ANA_MAX = 16'h7fff
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [15:0] analogInput,
  input wire logic        analogLost,
  input wire logic [1:0]  refSource,
  input wire logic        saturated,
  input wire logic [7:0]  sampleWindow
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // one wait state, then a single-cycle answer
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready unasked");
  a_err_read: assert property (pslverr && !$past(pwrite) |-> pready && prdata == 32'h0)
    else $error("bad read data");
  a_mapped_ok: assert property (pready && $past(paddr) == `ADDR_CONFIG_WORD |-> !pslverr)
    else $error("config refused");
  // saturation only in the saturating analogue mode
  a_sat_mode: assert property (saturated |-> refSource == `SRC_ANALOG_SAT)
    else $error("saturated outside mode");
  a_sat_clamp: assert property (refSource == `SRC_ANALOG_SAT && $past(analogInput) >= ANA_MAX |-> saturated)
    else $error("no clamp");
  a_sat_lost: assert property (refSource == `SRC_ANALOG_SAT && $past(analogLost) |-> saturated)
    else $error("lost input unsaturated");
  a_window_vals: assert property (sampleWindow == `WINDOW_SHORT || sampleWindow == `WINDOW_LONG)
    else $error("bad window");
endmodule // regulator_config_word_properties
bind regulator_config_word regulator_config_word_properties #(.ANA_MAX(ANA_MAX)) chk_i (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .analogInput(analogInput), .analogLost(analogLost),
  .refSource(refSource), .saturated(saturated), .sampleWindow(sampleWindow));

// ---- tb.sv ----
// self-checking bench for the configuration word block
`timescale 1ns/1ps
`include "regulator_config_consts.vh"
module tb;
  logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        jumper60Hz = 1, analogLost = 0, alarmRaw = 1, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [15:0] analogInput = 0, voltageTrimmer = 16'h0abc;
  wire         pready, pslverr, saturated, offsetCompEn, select60Hz, alarm_output_contact, extDacEn;
  wire         rmsRegulation, periodicRefEn, stabTrimEn, hzTrimEn, ampTrimEn;
  wire  [31:0] prdata;
  wire  [15:0] activeReference, voltageSetting;
  wire  [1:0]  refSource;
  wire  [7:0]  sampleWindow;
  int          n_errors = 0, checks = 0;
  regulator_config_word uut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .jumper60Hz(jumper60Hz), .analogInput(analogInput), .analogLost(analogLost),
    .voltageTrimmer(voltageTrimmer), .alarmRaw(alarmRaw), .activeReference(activeReference),
    .refSource(refSource), .saturated(saturated), .offsetCompEn(offsetCompEn), .sampleWindow(sampleWindow),
    .select60Hz(select60Hz), .voltageSetting(voltageSetting), .alarm_output_contact(alarm_output_contact),
    .rmsRegulation(rmsRegulation), .periodicRefEn(periodicRefEn), .stabTrimEn(stabTrimEn),
    .hzTrimEn(hzTrimEn), .ampTrimEn(ampTrimEn), .extDacEn(extDacEn));
  // free-running 100 MHz clock
  always #5 core_clk = ~core_clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // apb transfer; pready read at the rising edge, before that edge's own updates land
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 16'h0, d};
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    apb(1, a, d);
    repeat (3) @(posedge core_clk);
  endtask
  task rdc(input logic [11:0] a, input logic [15:0] e);
    apb(0, a, 16'h0);
    chk(rd, {16'h0, e});
    chk(er, 0);
  endtask
  task t_reset;
    rdc(`ADDR_CONFIG_WORD, `RST_CONFIG_WORD);
    chk(offsetCompEn, 1);
    chk(sampleWindow, `WINDOW_SHORT);
    chk(refSource, `SRC_ANALOG_FREE);
    chk(voltageSetting, 16'h0abc);
    chk(alarm_output_contact, 0);
    chk(select60Hz, 1);
    chk({rmsRegulation, periodicRefEn, stabTrimEn, hzTrimEn, ampTrimEn, extDacEn}, 6'b101110);
    jumper60Hz <= 0;
    repeat (2) @(posedge core_clk);
    chk(select60Hz, 0);
  endtask
  task t_bits;
    wr(`ADDR_CONFIG_WORD, 16'h8040);
    rdc(`ADDR_CONFIG_WORD, 16'h8040);
    chk({rmsRegulation, periodicRefEn, stabTrimEn, hzTrimEn, ampTrimEn, extDacEn}, 6'b000000);
    chk(offsetCompEn, 0);
    chk(sampleWindow, `WINDOW_LONG);
    chk(select60Hz, 0);
    chk(alarm_output_contact, 1);
    chk(voltageSetting, `RST_VOUT_REF_PARAM);
    wr(`ADDR_VOUT_REF_PARAM, 16'h1234);
    chk(voltageSetting, 16'h1234);
    wr(`ADDR_CONFIG_WORD, 16'h6000);
    chk(select60Hz, 1);
    chk(extDacEn, 1);
    apb(0, 12'h004, 16'h0);
    chk(er, 1);
    chk(rd, 32'h0);
    wr(`ADDR_CONFIG_WORD, 16'd1 + 16'd2 + 16'd512 + 16'd1024 + 16'd2048);
    rdc(`ADDR_CONFIG_WORD, 16'h0e03);
    chk({rmsRegulation, periodicRefEn, stabTrimEn, hzTrimEn, ampTrimEn, extDacEn}, 6'b111110);
  endtask
  // the four codes follow the order of this table
  task t_modes;
    logic [15:0] cfg [4];
    cfg = '{16'h1000, 16'h1080, 16'h0000, 16'h0080};
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CONFIG_WORD, cfg[i]);
      chk(refSource, i);
    end
  endtask
  task t_ref;
    wr(`ADDR_CONFIG_WORD, 16'h0000);
    wr(`ADDR_VOLATILE_REF, 16'h1111);
    rdc(`ADDR_VOLATILE_REF, `RST_STORED_REF);
    chk(activeReference, `RST_STORED_REF);
    wr(`ADDR_STORED_REF, 16'h3000);
    rdc(`ADDR_VOLATILE_REF, 16'h3000);
    wr(`ADDR_CONFIG_WORD, 16'h0080);
    wr(`ADDR_VOLATILE_REF, 16'h2222);
    chk(activeReference, 16'h2222);
  endtask
  task t_sat;
    wr(`ADDR_CONFIG_WORD, 16'h1080);
    analogLost <= 1;
    repeat (3) @(posedge core_clk);
    chk(saturated, 1);
    chk(activeReference, 16'h3000 + `RST_VARIATION_LIMIT);
    analogLost <= 0;
    analogInput <= 16'h9000;
    repeat (3) @(posedge core_clk);
    chk(saturated, 1);
    chk(activeReference, 16'h7fff);
    wr(`ADDR_CONFIG_WORD, 16'h1000);
    chk(saturated, 0);
    chk(activeReference, 16'h9000);
  endtask
  // image of parameters ten, fifteen, sixteen and nineteen taken from another unit, copied in and read back
  task t_copy;
    logic [15:0] img [4];
    logic [11:0] adr [4];
    img = '{16'h1f3d, 16'h2800, 16'h0900, 16'h0155};
    adr = '{`ADDR_CONFIG_WORD, `ADDR_STORED_REF, `ADDR_VARIATION_LIMIT, `ADDR_VOUT_REF_PARAM};
    for (int i = 0; i < 4; i++) wr(adr[i], img[i]);
    for (int i = 0; i < 4; i++) rdc(adr[i], img[i]);
  endtask
  // second reset in mid-run: defaults and the startup load come back
  task t_rst2;
    @(posedge core_clk);
    rstn <= 0;
    repeat (2) @(posedge core_clk);
    rstn <= 1;
    rdc(`ADDR_VOLATILE_REF, `RST_STORED_REF);
    rdc(`ADDR_CONFIG_WORD, `RST_CONFIG_WORD);
    chk(offsetCompEn, 1);
    chk(sampleWindow, `WINDOW_SHORT);
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1;
    t_reset;
    t_bits;
    t_modes;
    t_ref;
    t_sat;
    t_copy;
    t_rst2;
    wrap_up;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #50000;
    n_errors++;
    wrap_up;
  end
endmodule // tb
